// file: design/clock_prescale_and_stretch_control.sv
/*
  Clock control register with timer clock selects, watchdog period and
  external data move stretch, reached over APB, with event interrupt.
  Assumes clk is the oscillator, timer pins and move requests are
  synchronous to it, and a machine cycle is four oscillator clocks.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - timer2 fast bit picks divide-by-4 else 12
// - timer1 and timer0 fast bits likewise
// - watchdog bits pick 2^17/20/23/26 interrupt time-out
// - reset time-out is 512 clocks after interrupt
// - external move lasts stretch plus two cycles
// - read or write strobe lengthened by stretch
// - stretch resets to one, three machine cycles
// - on-chip SRAM move always two cycles
// - counter select uses pin falling edges instead
module clock_prescale_and_stretch_control #(
  parameter int WDT_EXP0 = 17,
  parameter int WDT_EXP1 = 20,
  parameter int WDT_EXP2 = 23,
  parameter int WDT_EXP3 = 26,
  parameter int WDT_CNT_W = 27
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // timers
  input  wire logic [2:0]  timerPin,
  output logic      [2:0]  timerTick,
  // external data move
  input  wire logic        xmoveStart,
  input  wire logic        xmoveWrite,
  input  wire logic        xmoveOnChip,
  output logic             extRdStrobe,
  output logic             extWrStrobe,
  output logic             xmoveBusy,
  output logic             xmoveDone,
  // watchdog and interrupt
  output logic             wdtReset,
  output logic             irq
);

  if (WDT_EXP0 < 10 || WDT_EXP3 > WDT_CNT_W - 1 || WDT_EXP0 > WDT_EXP1 ||
      WDT_EXP1 > WDT_EXP2 || WDT_EXP2 > WDT_EXP3) begin : g_bad_param
    $error("watchdog exponents do not fit the counter");
  end

  function automatic logic [WDT_CNT_W-1:0] wdt_limit(input logic [1:0] sel);
    logic [WDT_CNT_W-1:0] one;
    one = WDT_CNT_W'(1);
    case (sel)
      2'h0:    wdt_limit = one << WDT_EXP0;
      2'h1:    wdt_limit = one << WDT_EXP1;
      2'h2:    wdt_limit = one << WDT_EXP2;
      default: wdt_limit = one << WDT_EXP3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb register file
  logic [7:0]  clock_and_stretch_control_ff, nxt_clock_and_stretch_control;
  logic [2:0]  ctSel_ff, nxt_ctSel;
  logic        wdtEn_ff, nxt_wdtEn;
  logic        wdtRestart_ff, nxt_wdtRestart;
  logic [2:0]  status_ff, nxt_status;
  logic [2:0]  mask_ff, nxt_mask;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic        irq_ff, nxt_irq;
  logic        setup, wrAcc, mapped;
  logic [2:0]  evt;

  always_comb begin
    setup          = psel && !penable;
    wrAcc          = psel && penable && pready_ff && pwrite && !pslverr_ff;
    nxt_clock_and_stretch_control      = clock_and_stretch_control_ff;
    nxt_ctSel      = ctSel_ff;
    nxt_wdtEn      = wdtEn_ff;
    nxt_wdtRestart = 1'b0;
    nxt_mask       = mask_ff;
    nxt_prdata     = prdata_ff;
    nxt_pready     = setup;
    mapped         = 1'b1;
    if (paddr == clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_ADDR) begin
      nxt_prdata = {24'h000000, clock_and_stretch_control_ff};
    end else if (paddr == clk_ctrl_pkg::TMODE_ADDR) begin
      nxt_prdata = {29'h00000000, ctSel_ff};
    end else if (paddr == clk_ctrl_pkg::WDCTL_ADDR) begin
      nxt_prdata = {31'h00000000, wdtEn_ff};
    end else if (paddr == clk_ctrl_pkg::STATUS_ADDR) begin
      nxt_prdata = {29'h00000000, status_ff};
    end else if (paddr == clk_ctrl_pkg::MASK_ADDR) begin
      nxt_prdata = {29'h00000000, mask_ff};
    end else begin
      nxt_prdata = 32'h00000000;
      mapped     = 1'b0;
    end
    nxt_pslverr = setup ? !mapped : pslverr_ff && psel && penable && !pready_ff;
    if (!setup) begin
      nxt_prdata = prdata_ff;
    end
    // one write updates every field of the addressed register together
    if (wrAcc && paddr == clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_ADDR) begin
      nxt_clock_and_stretch_control = pwdata[7:0];
    end
    if (wrAcc && paddr == clk_ctrl_pkg::TMODE_ADDR) begin
      nxt_ctSel = pwdata[2:0];
    end
    if (wrAcc && paddr == clk_ctrl_pkg::WDCTL_ADDR) begin
      nxt_wdtEn      = pwdata[clk_ctrl_pkg::WDCTL_ENABLE];
      nxt_wdtRestart = pwdata[clk_ctrl_pkg::WDCTL_RESTART];
    end
    if (wrAcc && paddr == clk_ctrl_pkg::MASK_ADDR) begin
      nxt_mask = pwdata[2:0];
    end
    // set beats clear in the same cycle
    nxt_status = status_ff;
    if (wrAcc && paddr == clk_ctrl_pkg::STATUS_ADDR) begin
      nxt_status = status_ff & ~pwdata[2:0];
    end
    nxt_status = nxt_status | evt;
    nxt_irq    = |(nxt_status & mask_ff);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_and_stretch_control_ff      <= clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_RESET;
      ctSel_ff      <= clk_ctrl_pkg::TMODE_RESET;
      wdtEn_ff      <= clk_ctrl_pkg::WDCTL_RESET;
      wdtRestart_ff <= 1'b0;
      status_ff     <= clk_ctrl_pkg::EVT_RESET;
      mask_ff       <= clk_ctrl_pkg::EVT_RESET;
      prdata_ff     <= 32'h00000000;
      pready_ff     <= 1'b0;
      pslverr_ff    <= 1'b0;
      irq_ff        <= 1'b0;
    end else begin
      clock_and_stretch_control_ff      <= nxt_clock_and_stretch_control;
      ctSel_ff      <= nxt_ctSel;
      wdtEn_ff      <= nxt_wdtEn;
      wdtRestart_ff <= nxt_wdtRestart;
      status_ff     <= nxt_status;
      mask_ff       <= nxt_mask;
      prdata_ff     <= nxt_prdata;
      pready_ff     <= nxt_pready;
      pslverr_ff    <= nxt_pslverr;
      irq_ff        <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer clock selection
  logic       div4Tick, div12Tick;
  logic [2:0] pinPrev_ff, nxt_pinPrev;
  logic [2:0] tick_ff, nxt_tick;
  logic [2:0] fastSel, pinFall;

  osc_prescaler u_prescaler (
    .clk       (clk),
    .reset     (reset),
    .div4Tick  (div4Tick),
    .div12Tick (div12Tick)
  );

  assign fastSel = {clock_and_stretch_control_ff[clk_ctrl_pkg::T2_FAST], clock_and_stretch_control_ff[clk_ctrl_pkg::T1_FAST],
                    clock_and_stretch_control_ff[clk_ctrl_pkg::T0_FAST]};

  for (genvar i = 0; i < 3; i++) begin : g_timer
    always_comb begin
      nxt_pinPrev[i] = timerPin[i];
      pinFall[i]     = pinPrev_ff[i] && !timerPin[i];
      if (ctSel_ff[i]) begin
        nxt_tick[i] = pinFall[i];
      end else begin
        nxt_tick[i] = fastSel[i] ? div4Tick : div12Tick;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pinPrev_ff <= 3'h7;
      tick_ff    <= 3'h0;
    end else begin
      pinPrev_ff <= nxt_pinPrev;
      tick_ff    <= nxt_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  logic [WDT_CNT_W-1:0] wdtLimit, wdtCount;
  logic                 wdtIntPulse, wdtRstPulse;
  logic                 wdtReset_ff, nxt_wdtReset;

  assign wdtLimit = wdt_limit(clock_and_stretch_control_ff[clk_ctrl_pkg::WD_SEL_HI:clk_ctrl_pkg::WD_SEL_LO]);

  wdt_counter #(
    .CNT_W (WDT_CNT_W)
  ) u_wdt (
    .clk      (clk),
    .reset    (reset),
    .enable   (wdtEn_ff),
    .restart  (wdtRestart_ff),
    .intLimit (wdtLimit),
    .count    (wdtCount),
    .intPulse (wdtIntPulse),
    .rstPulse (wdtRstPulse)
  );

  assign nxt_wdtReset = wdtRstPulse;

  ////////////////////////////////////////////////////////////////////////////
  // external data move sequencer
  clk_ctrl_pkg::xmove_state_e xmState_ff, nxt_xmState;
  logic [1:0] clkCnt_ff, nxt_clkCnt;
  logic [3:0] mc_ff, nxt_mc;
  logic [3:0] mcLast_ff, nxt_mcLast;
  logic       onChip_ff, nxt_onChip;
  logic       isWrite_ff, nxt_isWrite;
  logic       rdStb_ff, nxt_rdStb, wrStb_ff, nxt_wrStb;
  logic       done_ff, nxt_done;

  always_comb begin
    nxt_xmState = xmState_ff;
    nxt_clkCnt  = clkCnt_ff;
    nxt_mc      = mc_ff;
    nxt_mcLast  = mcLast_ff;
    nxt_onChip  = onChip_ff;
    nxt_isWrite = isWrite_ff;
    nxt_done    = 1'b0;
    case (xmState_ff)
      clk_ctrl_pkg::XM_IDLE: begin
        if (xmoveStart) begin
          // settings taken at the start, so a mid-move write waits
          nxt_xmState = clk_ctrl_pkg::XM_RUN;
          nxt_clkCnt  = 2'h0;
          nxt_mc      = 4'h0;
          nxt_onChip  = xmoveOnChip;
          nxt_isWrite = xmoveWrite;
          nxt_mcLast  = xmoveOnChip ? 4'(clk_ctrl_pkg::XMOVE_BASE_MC - 1)
                      : 4'(clock_and_stretch_control_ff[2:0]) + 4'(clk_ctrl_pkg::XMOVE_BASE_MC - 1);
        end
      end
      clk_ctrl_pkg::XM_RUN: begin
        nxt_clkCnt = clkCnt_ff + 2'h1;
        if (clkCnt_ff == 2'(clk_ctrl_pkg::MACH_CYCLE_CLKS - 1)) begin
          nxt_mc = mc_ff + 4'h1;
          if (mc_ff == mcLast_ff) begin
            nxt_xmState = clk_ctrl_pkg::XM_IDLE;
            nxt_done    = 1'b1;
          end
        end
      end
      default: nxt_xmState = clk_ctrl_pkg::XM_IDLE;
    endcase
    // strobe covers every cycle after the first, so it grows by the stretch
    nxt_rdStb = (nxt_xmState == clk_ctrl_pkg::XM_RUN) && nxt_mc != 4'h0
                && !nxt_onChip && !nxt_isWrite;
    nxt_wrStb = (nxt_xmState == clk_ctrl_pkg::XM_RUN) && nxt_mc != 4'h0
                && !nxt_onChip && nxt_isWrite;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xmState_ff  <= clk_ctrl_pkg::XM_IDLE;
      clkCnt_ff   <= 2'h0;
      mc_ff       <= 4'h0;
      mcLast_ff   <= 4'h0;
      onChip_ff   <= 1'b0;
      isWrite_ff  <= 1'b0;
      rdStb_ff    <= 1'b0;
      wrStb_ff    <= 1'b0;
      done_ff     <= 1'b0;
      wdtReset_ff <= 1'b0;
    end else begin
      xmState_ff  <= nxt_xmState;
      clkCnt_ff   <= nxt_clkCnt;
      mc_ff       <= nxt_mc;
      mcLast_ff   <= nxt_mcLast;
      onChip_ff   <= nxt_onChip;
      isWrite_ff  <= nxt_isWrite;
      rdStb_ff    <= nxt_rdStb;
      wrStb_ff    <= nxt_wrStb;
      done_ff     <= nxt_done;
      wdtReset_ff <= nxt_wdtReset;
    end
  end

  assign evt = {nxt_done, wdtRstPulse, wdtIntPulse};

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign timerTick   = tick_ff;
  assign extRdStrobe = rdStb_ff;
  assign extWrStrobe = wrStb_ff;
  assign xmoveBusy   = (xmState_ff == clk_ctrl_pkg::XM_RUN);
  assign xmoveDone   = done_ff;
  assign wdtReset    = wdtReset_ff;
  assign irq         = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [6:0] busyLen_ff, stbLen_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busyLen_ff <= 7'h00;
      stbLen_ff  <= 7'h00;
    end else begin
      busyLen_ff <= xmoveBusy ? busyLen_ff + 7'h01 : 7'h00;
      stbLen_ff  <= (rdStb_ff || wrStb_ff) ? stbLen_ff + 7'h01 : 7'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  t2_fast_a: assert property (clock_and_stretch_control_ff[5] && !ctSel_ff[2] && $stable(clock_and_stretch_control_ff)
    |=> timerTick[2] == $past(div4Tick)) else $error("timer2 fast clock wrong");
  t1_slow_a: assert property (!clock_and_stretch_control_ff[4] && !ctSel_ff[1] && $stable(clock_and_stretch_control_ff)
    |=> timerTick[1] == $past(div12Tick)) else $error("timer1 slow clock wrong");
  wdt_int_a: assert property (wdtIntPulse |-> wdtCount == wdtLimit)
    else $error("watchdog interrupt at wrong count");
  wdt_rst_a: assert property (wdtRstPulse |-> wdtCount == wdtLimit + WDT_CNT_W'(512)
    ##1 wdtReset) else $error("watchdog reset not 512 after interrupt");
  move_len_a: assert property (xmoveDone |-> busyLen_ff == 7'((mcLast_ff + 4'h1) * 4))
    else $error("external move length wrong");
  stb_len_a: assert property ($fell(rdStb_ff || wrStb_ff) |-> stbLen_ff == 7'(mcLast_ff * 4))
    else $error("strobe not stretched");
  onchip_a: assert property (!xmoveBusy && xmoveStart && xmoveOnChip |->
    ##9 xmoveDone) else $error("on-chip move not two cycles");
  ext_pin_a: assert property (ctSel_ff[0] && $stable(ctSel_ff) |=>
    timerTick[0] == $past(pinFall[0])) else $error("counter mode tick wrong");
  ck_write_a: assert property (wrAcc && paddr == 12'h238 |=> clock_and_stretch_control_ff == $past(pwdata[7:0]))
    else $error("clock control write lost");
  rst_val_a: assert property (@(posedge clk) disable iff (1'b0) $fell(reset) |->
    clock_and_stretch_control_ff[2:0] == 3'h1) else $error("stretch reset value wrong");

  cov_ext_move_c: cover property (xmoveStart && !xmoveOnChip && !xmoveBusy ##1 xmoveBusy);
  cov_wdt_int_c:  cover property (wdtIntPulse);
  cov_irq_c:      cover property ($rose(irq));

endmodule

// file: design/clk_ctrl_pkg.sv
/*
  Shared constants for the clock prescale and stretch control block:
  register map, field positions, reset values, timing counts, states.
  Assumes a 32-bit APB with 12-bit byte addresses, one word per register.
*/
package clk_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; the byte address is four times the index
  localparam logic [11:0] CLOCK_AND_STRETCH_CONTROL_INDEX  = 12'h08E;
  localparam logic [11:0] TMODE_INDEX  = 12'h090;
  localparam logic [11:0] WDCTL_INDEX  = 12'h091;
  localparam logic [11:0] STATUS_INDEX = 12'h092;
  localparam logic [11:0] MASK_INDEX   = 12'h093;
  localparam logic [11:0] CLOCK_AND_STRETCH_CONTROL_ADDR   = 12'(CLOCK_AND_STRETCH_CONTROL_INDEX * 4);
  localparam logic [11:0] TMODE_ADDR   = 12'(TMODE_INDEX * 4);
  localparam logic [11:0] WDCTL_ADDR   = 12'(WDCTL_INDEX * 4);
  localparam logic [11:0] STATUS_ADDR  = 12'(STATUS_INDEX * 4);
  localparam logic [11:0] MASK_ADDR    = 12'(MASK_INDEX * 4);

  ////////////////////////////////////////////////////////////////////////////
  // clock_and_stretch_control fields
  localparam int WD_SEL_HI  = 7;
  localparam int WD_SEL_LO  = 6;
  localparam int T2_FAST    = 5;
  localparam int T1_FAST    = 4;
  localparam int T0_FAST    = 3;
  localparam int STRETCH_HI = 2;
  localparam int STRETCH_LO = 0;
  localparam logic [7:0] CLOCK_AND_STRETCH_CONTROL_RESET = 8'h01;

  // own registers: counter selects, watchdog control, events
  localparam int WDCTL_ENABLE  = 0;
  localparam int WDCTL_RESTART = 1;
  localparam logic [2:0] TMODE_RESET = 3'h0;
  localparam logic [0:0] WDCTL_RESET = 1'h0;
  localparam int EVT_WDT_INT  = 0;
  localparam int EVT_WDT_RST  = 1;
  localparam int EVT_XM_DONE  = 2;
  localparam int NUM_EVT      = 3;
  localparam logic [2:0] EVT_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing counts in oscillator clocks; XMOVE_BASE_MC in machine cycles
  localparam int DIV_FAST         = 4;
  localparam int DIV_SLOW         = 12;
  localparam int WDT_RESET_EXTRA  = 512;
  localparam int MACH_CYCLE_CLKS  = 4;
  localparam int XMOVE_BASE_MC    = 2;

  typedef enum logic [0:0] {XM_IDLE, XM_RUN} xmove_state_e;

endpackage

// file: design/osc_prescaler.sv
/*
  Divide-by-4 and divide-by-12 one-cycle enable pulses from the oscillator.
  Assumes clk is the oscillator clock itself.
*/
`timescale 1ns/100ps
module osc_prescaler (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // enables
  output logic      div4Tick,
  output logic      div12Tick
);

  logic [1:0] fastCnt_ff, nxt_fastCnt;
  logic [3:0] slowCnt_ff, nxt_slowCnt;

  always_comb begin
    nxt_fastCnt = (fastCnt_ff == 2'(clk_ctrl_pkg::DIV_FAST - 1)) ? 2'h0 : fastCnt_ff + 2'h1;
    nxt_slowCnt = (slowCnt_ff == 4'(clk_ctrl_pkg::DIV_SLOW - 1)) ? 4'h0 : slowCnt_ff + 4'h1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fastCnt_ff <= 2'h0;
      slowCnt_ff <= 4'h0;
    end else begin
      fastCnt_ff <= nxt_fastCnt;
      slowCnt_ff <= nxt_slowCnt;
    end
  end

  assign div4Tick  = (fastCnt_ff == 2'(clk_ctrl_pkg::DIV_FAST - 1));
  assign div12Tick = (slowCnt_ff == 4'(clk_ctrl_pkg::DIV_SLOW - 1));

endmodule

// file: design/wdt_counter.sv
/*
  Watchdog up-counter with interrupt and reset time-out pulses.
  Assumes the limit input is held stable while the count runs.
*/
`timescale 1ns/100ps
module wdt_counter #(
  parameter int CNT_W = 27
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // control
  input  wire logic             enable,
  input  wire logic             restart,
  input  wire logic [CNT_W-1:0] intLimit,
  // results
  output logic      [CNT_W-1:0] count,
  output logic                  intPulse,
  output logic                  rstPulse
);

  logic [CNT_W-1:0] count_ff, nxt_count, rstLimit;
  logic             intPulse_ff, nxt_intPulse;
  logic             rstPulse_ff, nxt_rstPulse;

  always_comb begin
    rstLimit     = intLimit + CNT_W'(clk_ctrl_pkg::WDT_RESET_EXTRA);
    nxt_count    = count_ff;
    if (restart || !enable) begin
      nxt_count = '0;
    end else if (count_ff != rstLimit) begin
      // parks at the reset limit so the reset fires once
      nxt_count = count_ff + CNT_W'(1);
    end
    nxt_intPulse = enable && !restart && (count_ff != nxt_count) && (nxt_count == intLimit);
    nxt_rstPulse = enable && !restart && (count_ff != nxt_count) && (nxt_count == rstLimit);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_ff    <= '0;
      intPulse_ff <= 1'b0;
      rstPulse_ff <= 1'b0;
    end else begin
      count_ff    <= nxt_count;
      intPulse_ff <= nxt_intPulse;
      rstPulse_ff <= nxt_rstPulse;
    end
  end

  assign count    = count_ff;
  assign intPulse = intPulse_ff;
  assign rstPulse = rstPulse_ff;

endmodule

// file: bench/ext_mem_model.sv
/*
  External memory side of the data move: measures each strobe burst.
  Assumes strobes are synchronous to clk and never overlap.
*/
`timescale 1ns/100ps
module ext_mem_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // strobes from the block
  input  wire logic       extRdStrobe,
  input  wire logic       extWrStrobe,
  // measured access
  output logic      [7:0] strobeLen,
  output logic            strobeWr,
  output logic            strobeEnd
);
  logic [7:0] runLen;

  ////////////////////////////////////////////////////////////////////////////
  // a slow device simply holds off until the strobe ends, so length is all
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      runLen    <= 8'h00;
      strobeLen <= 8'h00;
      strobeWr  <= 1'b0;
      strobeEnd <= 1'b0;
    end else begin
      strobeEnd <= 1'b0;
      if (extRdStrobe || extWrStrobe) begin
        runLen   <= runLen + 8'h01;
        strobeWr <= extWrStrobe;
      end else if (runLen != 8'h00) begin
        strobeLen <= runLen;
        strobeEnd <= 1'b1;
        runLen    <= 8'h00;
      end
    end
  end
endmodule

// file: bench/clock_prescale_and_stretch_control_test.sv
/*
  Self-checking bench: registers over APB, timer ticks, data moves, watchdog.
  Assumes zero-wait APB and small watchdog exponents 10..13.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module clock_prescale_and_stretch_control_test;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000F80A;
  logic        pready, pslverr, extRdStrobe, extWrStrobe, xmoveBusy;
  logic        xmoveDone, wdtReset, irq, strobeWr, strobeEnd;
  logic [2:0]  timerPin = 3'h7, timerTick;
  logic        xmoveStart = 1'b0, xmoveWrite = 1'b0, xmoveOnChip = 1'b0;
  logic [7:0]  strobeLen;
  logic [32:0] readQ[$];
  logic [8:0]  strobeQ[$];
  int          moveQ[$];
  int          failures = 0, cmp_count = 0, cyc = 0, startCyc = 0;
  int          g, k, cnt, r, tI[4];
  logic [31:0] v;

  always #25 clk = ~clk;

  clock_prescale_and_stretch_control #(.WDT_EXP0(10), .WDT_EXP1(11), .WDT_EXP2(12),
    .WDT_EXP3(13)) i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerPin(timerPin), .timerTick(timerTick),
    .xmoveStart(xmoveStart), .xmoveWrite(xmoveWrite), .xmoveOnChip(xmoveOnChip),
    .extRdStrobe(extRdStrobe), .extWrStrobe(extWrStrobe), .xmoveBusy(xmoveBusy),
    .xmoveDone(xmoveDone), .wdtReset(wdtReset), .irq(irq));

  ext_mem_model i_mem (.clk(clk), .reset(reset), .extRdStrobe(extRdStrobe),
    .extWrStrobe(extWrStrobe), .strobeLen(strobeLen), .strobeWr(strobeWr),
    .strobeEnd(strobeEnd));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    readQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // start pulse; taking edge is the second edge
  task automatic kick(input int n, input logic wr, input logic oc);
    moveQ.push_back(oc ? 8 : (n + 2) * 4);
    if (!oc) strobeQ.push_back({wr, 8'((n + 1) * 4)});
    @(posedge clk);
    xmoveStart  <= 1'b1;
    xmoveWrite  <= wr;
    xmoveOnChip <= oc;
    @(posedge clk);
    xmoveStart <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (xmoveDone !== 1'b1 && n < 100);
  endtask

  task automatic gap(input int i, output int p);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (timerTick[i] !== 1'b1 && n < 40);
    end
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (timerTick[i] !== 1'b1 && p < 40);
  endtask

  task automatic print_verdict();
    if (readQ.size() + moveQ.size() + strobeQ.size() != 0) failures++;
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // result watcher: oldest note against each result seen
  always @(posedge clk) begin
    cyc++;
    if (psel && penable && pready && !pwrite) begin
      `CHK({pslverr, prdata}, (readQ.size() ? readQ.pop_front() : 33'hX))
    end
    if (xmoveDone === 1'b1) begin
      `CHK(cyc - startCyc - 1, (moveQ.size() ? moveQ.pop_front() : -1))
    end
    if (xmoveStart && !xmoveBusy) startCyc = cyc;
    if (strobeEnd === 1'b1) begin
      `CHK({strobeWr, strobeLen}, (strobeQ.size() ? strobeQ.pop_front() : 9'hX))
    end
  end

  // hang guard well past the longest watchdog run
  initial begin
    #(60000 * 50);
    failures++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_ADDR, 33'h001);
    rd(clk_ctrl_pkg::TMODE_ADDR, 33'h0);
    rd(clk_ctrl_pkg::STATUS_ADDR, 33'h0);
    apb(1'b1, 12'h004, 32'hFF);
    rd(12'h004, 33'h100000000);
    repeat (4) begin
      v = xs();
      apb(1'b1, clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_ADDR, v);
      rd(clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_ADDR, {25'h0, v[7:0]});
    end
    // timer dividers, two mixed selections
    foreach (tI[c]) tI[c] = 0;
    for (int c = 0; c < 2; c++) begin
      v = c ? 32'h11 : 32'h29;
      apb(1'b1, clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_ADDR, v);
      for (int i = 0; i < 3; i++) begin
        gap(i, g);
        `CHK(g, (v[3 + i] ? 4 : 12))
      end
    end
    // counter mode: ticks follow falling pin edges only
    apb(1'b1, clk_ctrl_pkg::TMODE_ADDR, 32'h7);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      k = 1 + int'(xs() % 4);
      cnt = 0;
      for (int j = 0; j < 6 * k + 4; j++) begin
        @(posedge clk);
        cnt += int'(timerTick[i]);
        timerPin[i] <= (j < 6 * k) ? ((j % 6) >= 3) : 1'b1;
      end
      `CHK(cnt, k)
    end
    // every stretch code, reads on even codes and writes on odd, then on-chip
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_ADDR, 32'(n));
      kick(n, n[0], 1'b0);
      wait_done();
    end
    kick(7, 1'(xs()), 1'b1);
    wait_done();
    // start while busy is ignored, then a start in the done cycle
    apb(1'b1, clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_ADDR, 32'h3);
    kick(3, 1'b1, 1'b0);
    repeat (5) @(posedge clk);
    xmoveStart <= 1'b1;
    @(posedge clk);
    xmoveStart <= 1'b0;
    repeat (13) @(posedge clk);
    kick(3, 1'b0, 1'b0);
    wait_done();
    // move-done event, masked then unmasked, then cleared
    rd(clk_ctrl_pkg::STATUS_ADDR, 33'h4);
    `CHK(irq, 1'b0)
    apb(1'b1, clk_ctrl_pkg::MASK_ADDR, 32'h4);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, clk_ctrl_pkg::STATUS_ADDR, 32'h4);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    // watchdog periods per code; offsets cancel in differences
    apb(1'b1, clk_ctrl_pkg::MASK_ADDR, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, clk_ctrl_pkg::CLOCK_AND_STRETCH_CONTROL_ADDR, 32'(c << 6) | 32'h1);
      apb(1'b1, clk_ctrl_pkg::STATUS_ADDR, 32'h3);
      apb(1'b1, clk_ctrl_pkg::WDCTL_ADDR, 32'h3);
      g = 0;
      do begin
        @(posedge clk);
        g++;
      end while (irq !== 1'b1 && g < 20000);
      r = 0;
      do begin
        @(posedge clk);
        r++;
      end while (wdtReset !== 1'b1 && r < 2000);
      `CHK(r, 512)
      tI[c] = g;
    end
    for (int c = 1; c < 4; c++) begin
      `CHK(tI[c] - tI[0], (1 << (10 + c)) - 1024)
    end
    print_verdict();
  end
endmodule
